/* rtl/crc_word_fifo.sv */
// word fifo feeding the crc shift engine
`timescale 1ns/100ps
module crc_word_fifo
    import crc_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int LVLW = 5
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic [LVLW-1:0] depthLimit,
    input wire logic pushValid,
    input wire logic [WIDTH-1:0] pushData,
    output logic pushReady,
    output logic popValid,
    input wire logic popReady,
    output logic [WIDTH-1:0] popData,
    output logic [LVLW-1:0] level
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_ff;
    logic [PW-1:0] rdPtr_ff;
    logic [LVLW-1:0] level_ff;
    logic [LVLW-1:0] nxt_level;
    wire pushFire;
    wire popFire;

    // ****************************************************************
    // handshake and level
    // ****************************************************************
    assign pushReady = level_ff < depthLimit;
    assign popValid = level_ff != '0;
    assign pushFire = pushValid && pushReady && !flush;
    assign popFire = popValid && popReady && !flush;
    assign popData = mem[rdPtr_ff];
    assign level = level_ff;
    assign nxt_level = pushFire && !popFire ? level_ff + LVLW'(1) :
                       popFire && !pushFire ? level_ff - LVLW'(1) : level_ff;

    always_ff @(posedge sys_clk) begin
        if (pushFire) begin
            mem[wrPtr_ff] <= pushData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || flush) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            level_ff <= '0;
        end else begin
            wrPtr_ff <= pushFire ? wrPtr_ff + PW'(1) : wrPtr_ff;
            rdPtr_ff <= popFire ? rdPtr_ff + PW'(1) : rdPtr_ff;
            level_ff <= nxt_level;
        end
    end
endmodule // crc_word_fifo

/* rtl/programmable_crc_engine.sv */
// programmable crc generator with word fifo and register port
//
// How it works
// R1 - polynomial order up to 32, highest exponent set by control_two bits 4..0
// R2 - each set term bit adds an xor tap at that engine bit
// R3 - constant term always fed back, lowest term bit ignored
// R4 - order 32 implies the top term; term bits cover exponents 31..1
// R5 - word width is control_two bits 12..8 plus one, 1 to 32
// R6 - fifo depth 4 above width field 15, 8 for width field 8..15, 16 below width field 8
// R7 - narrow words written whole; bits above the width are dropped
// R8 - valid word count rises when the part holding the top bit is written
// R9 - software writes low data half before high half of each word
// R10 - shifting starts only with go bit set and count nonzero
// R11 - fifo head moves to holding buffer, count falls at that move
// R12 - two bits shifted per cycle, 32-bit word in 16 cycles
// R13 - full flag bit 7 set when count reaches the current depth
// R14 - empty flag bit 6 set when count is zero
// R15 - module enable low empties fifo and forces count to zero
// R16 - software waits one cycle after a data write before reading count
// R17 - result register keeps the remainder once shifting stops
`timescale 1ns/100ps
`include "crc_params.svh"
module programmable_crc_engine
    import crc_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    output logic irq
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic enable_ff;
    logic goBit_ff;
    logic [4:0] polyLen_ff;
    logic [4:0] widthField_ff;
    reg16_t termsLo_ff;
    reg16_t termsHi_ff;
    reg16_t dataLo_ff;
    word32_t remainder_ff;
    word32_t nxt_remainder;
    word32_t holdBuf_ff;
    logic [5:0] bitsLeft_ff;
    logic [5:0] nxt_bitsLeft;
    eng_state_t state_ff;
    logic wordDone_ff;
    logic [2:0] irqStat_ff;
    logic [2:0] irqEn_ff;
    logic emptyPrev_ff;
    logic fullPrev_ff;
    reg16_t rdData_ff;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire wrCtrl1 = regWrite && regAddr == `CRC_ADDR_CTRL1;
    wire wrCtrl2 = regWrite && regAddr == `CRC_ADDR_CTRL2;
    wire wrTermsLo = regWrite && regAddr == `CRC_ADDR_TERMS_LO;
    wire wrTermsHi = regWrite && regAddr == `CRC_ADDR_TERMS_HI;
    wire wrDataLo = regWrite && regAddr == `CRC_ADDR_DATA_LO;
    wire wrDataHi = regWrite && regAddr == `CRC_ADDR_DATA_HI;
    wire wrResLo = regWrite && regAddr == `CRC_ADDR_RESULT_LO;
    wire wrResHi = regWrite && regAddr == `CRC_ADDR_RESULT_HI;
    wire wrIrqClr = regWrite && regAddr == `CRC_ADDR_IRQ_CLR;
    wire wrIrqEn = regWrite && regAddr == `CRC_ADDR_IRQ_EN;

    // ****************************************************************
    // word assembly and fifo
    // ****************************************************************
    wire wideWord = widthField_ff >= `CRC_WIDTH_WIDE_MIN;
    wire [4:0] depthLimit = wideWord ? `CRC_DEPTH_WIDE :
                            widthField_ff >= `CRC_WIDTH_MID_MIN ? `CRC_DEPTH_MID :
                            `CRC_DEPTH_NARROW; // [R6]
    wire word32_t widthMask = 32'hFFFFFFFF >> (5'h1F - widthField_ff); // [R5]
    // commit on the half that holds the top bit of the word
    wire commitWord = enable_ff && ((wrDataLo && !wideWord) || (wrDataHi && wideWord)); // [R8]
    wire word32_t rawWord = wideWord ? {regWrData, dataLo_ff} : {16'h0000, regWrData}; // [R9]
    wire word32_t pushWord = rawWord & widthMask; // [R7]
    wire stIdle = state_ff == ST_IDLE;
    wire stShift = state_ff == ST_SHIFT;
    wire [4:0] fifoLevel;
    wire fifoHasWord;
    wire fifoPushReady;
    wire word32_t fifoHead;
    wire startWord = stIdle && enable_ff && goBit_ff && fifoHasWord; // [R10]

    crc_word_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH),
        .LVLW(5)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(!enable_ff), // [R15]
        .depthLimit(depthLimit),
        .pushValid(commitWord),
        .pushData(pushWord),
        .pushReady(fifoPushReady),
        .popValid(fifoHasWord),
        .popReady(startWord), // [R11]
        .popData(fifoHead),
        .level(fifoLevel)
    );

    wire fifoFull = fifoLevel == depthLimit; // [R13]
    wire fifoEmpty = fifoLevel == 5'h00; // [R14]

    // ****************************************************************
    // shift engine
    // ****************************************************************
    function automatic word32_t crcStep(input word32_t r, input logic b, input word32_t terms,
                                        input logic [4:0] poly_length_field);
        logic fb;
        word32_t n;
        fb = r[poly_length_field] ^ b; // [R1] [R4]
        n = {r[30:0], 1'b0} ^ ({terms[31:1], 1'b1} & {32{fb}}); // [R2] [R3]
        crcStep = n & (32'hFFFFFFFF >> (5'h1F - poly_length_field));
    endfunction

    wire word32_t polyTerms = {termsHi_ff, termsLo_ff};
    wire twoBits = bitsLeft_ff >= 6'h02;
    wire [4:0] idxHi = 5'(bitsLeft_ff - 6'h01);
    wire [4:0] idxLo = 5'(bitsLeft_ff - 6'h02);
    wire word32_t stepOne = crcStep(remainder_ff, holdBuf_ff[idxHi], polyTerms, polyLen_ff);
    wire word32_t stepTwo = crcStep(stepOne, holdBuf_ff[idxLo], polyTerms, polyLen_ff);
    wire lastStep = stShift && !(twoBits && bitsLeft_ff != 6'h02);

    assign nxt_bitsLeft = twoBits ? bitsLeft_ff - 6'h02 : 6'h00; // [R12]
    assign nxt_remainder = !stShift ? remainder_ff : twoBits ? stepTwo : stepOne;

    always_ff @(posedge sys_clk) begin
        if (rst || !enable_ff) begin
            state_ff <= ST_IDLE;
            bitsLeft_ff <= 6'h00;
            wordDone_ff <= 1'b0;
        end else begin
            wordDone_ff <= lastStep;
            case (state_ff)
                ST_IDLE: begin
                    if (startWord) begin
                        state_ff <= ST_SHIFT;
                        bitsLeft_ff <= {1'b0, widthField_ff} + 6'h01;
                    end
                end
                ST_SHIFT: begin
                    bitsLeft_ff <= nxt_bitsLeft;
                    if (lastStep) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (startWord) begin
            holdBuf_ff <= fifoHead; // [R11]
        end
    end

    // remainder stays put while idle unless a result half is written, so the result survives the drain
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            remainder_ff <= `CRC_RST_REM;
        end else if (stIdle && wrResLo) begin
            remainder_ff <= {remainder_ff[31:16], regWrData};
        end else if (stIdle && wrResHi) begin
            remainder_ff <= {regWrData, remainder_ff[15:0]};
        end else begin
            remainder_ff <= nxt_remainder; // [R17]
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            enable_ff <= 1'b0;
            goBit_ff <= 1'b0;
            polyLen_ff <= 5'h00;
            widthField_ff <= 5'h00;
            termsLo_ff <= `CRC_RST_REG16;
            termsHi_ff <= `CRC_RST_REG16;
            dataLo_ff <= `CRC_RST_REG16;
            irqEn_ff <= `CRC_RST_IRQ;
        end else begin
            if (wrCtrl1) begin
                enable_ff <= regWrData[`CRC_EN_BIT];
                goBit_ff <= regWrData[`CRC_GO_BIT];
            end
            if (wrCtrl2) begin
                polyLen_ff <= regWrData[`CRC_POLY_LENGTH_FIELD_LSB +: 5]; // [R1]
                widthField_ff <= regWrData[`CRC_WIDTH_LSB +: 5]; // [R5]
            end
            if (wrTermsLo) begin
                termsLo_ff <= regWrData;
            end
            if (wrTermsHi) begin
                termsHi_ff <= regWrData;
            end
            if (wrDataLo) begin
                dataLo_ff <= regWrData;
            end
            if (wrIrqEn) begin
                irqEn_ff <= regWrData[2:0];
            end
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    wire [2:0] irqEvents = {fifoFull && !fullPrev_ff, fifoEmpty && !emptyPrev_ff, wordDone_ff};
    wire [2:0] irqClrMask = wrIrqClr ? regWrData[2:0] : 3'h0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqStat_ff <= `CRC_RST_IRQ;
            emptyPrev_ff <= 1'b1;
            fullPrev_ff <= 1'b0;
        end else begin
            irqStat_ff <= (irqStat_ff & ~irqClrMask) | irqEvents;
            emptyPrev_ff <= fifoEmpty;
            fullPrev_ff <= fifoFull;
        end
    end

    assign irq = |(irqStat_ff & irqEn_ff);

    // ****************************************************************
    // read port
    // ****************************************************************
    wire reg16_t ctrl1View = {enable_ff, 2'b00, fifoLevel, fifoFull, fifoEmpty, 1'b0, goBit_ff, 4'h0};
    wire reg16_t ctrl2View = {3'b000, widthField_ff, 3'b000, polyLen_ff};
    wire reg16_t readMux =
        regAddr == `CRC_ADDR_CTRL1 ? ctrl1View :
        regAddr == `CRC_ADDR_CTRL2 ? ctrl2View :
        regAddr == `CRC_ADDR_TERMS_LO ? termsLo_ff :
        regAddr == `CRC_ADDR_TERMS_HI ? termsHi_ff :
        regAddr == `CRC_ADDR_DATA_LO ? dataLo_ff :
        regAddr == `CRC_ADDR_RESULT_LO ? remainder_ff[15:0] :
        regAddr == `CRC_ADDR_RESULT_HI ? remainder_ff[31:16] :
        regAddr == `CRC_ADDR_IRQ_STAT ? {13'h0000, irqStat_ff} :
        regAddr == `CRC_ADDR_IRQ_EN ? {13'h0000, irqEn_ff} : 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_ff <= `CRC_RST_REG16;
        end else begin
            rdData_ff <= regRead ? readMux : 16'h0000;
        end
    end

    assign regRdData = rdData_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_start_needs_go;
        stIdle && !(goBit_ff && fifoLevel != 5'h00) |=> stIdle;
    endproperty
    a_start_needs_go: assert property (p_start_needs_go) else $error("engine left idle without go and word"); // [R10]

    property p_start_pop;
        startWord && !commitWord |=> stShift && fifoLevel == $past(fifoLevel) - 5'h01;
    endproperty
    a_start_pop: assert property (p_start_pop) else $error("count not decremented at word move"); // [R11]

    property p_commit_inc;
        commitWord && fifoPushReady && !startWord |=> fifoLevel == $past(fifoLevel) + 5'h01;
    endproperty
    a_commit_inc: assert property (p_commit_inc) else $error("count not incremented on commit"); // [R8]

    property p_disable_clears;
        !enable_ff |=> fifoLevel == 5'h00 && stIdle;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("disabled engine holds words"); // [R15]

    property p_word32_time;
        $rose(stShift) && widthField_ff == 5'h1F && $stable(widthField_ff) |-> stShift [*8] ##1 stShift [*8] ##1 stIdle;
    endproperty
    a_word32_time: assert property (p_word32_time) else $error("32-bit word not done in 16 cycles"); // [R12]

    property p_empty_read;
        regRead && regAddr == `CRC_ADDR_CTRL1 && fifoLevel == 5'h00 |=> regRdData[`CRC_EMPTY_BIT];
    endproperty
    a_empty_read: assert property (p_empty_read) else $error("empty flag not read back"); // [R14]

    property p_full_read;
        regRead && regAddr == `CRC_ADDR_CTRL1 && fifoLevel == depthLimit |=> regRdData[`CRC_FULL_BIT];
    endproperty
    a_full_read: assert property (p_full_read) else $error("full flag not read back"); // [R13]

    property p_depth_bound;
        fifoLevel <= depthLimit || $changed(widthField_ff);
    endproperty
    a_depth_bound: assert property (p_depth_bound) else $error("count beyond depth"); // [R6]

    property p_result_hold;
        stIdle && !wrResLo && !wrResHi ##1 stIdle |-> $stable(remainder_ff);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("remainder moved while idle"); // [R17]

    property p_mask_width;
        commitWord && widthField_ff != 5'h1F |-> (pushWord >> ({1'b0, widthField_ff} + 6'h01)) == 32'h00000000;
    endproperty
    a_mask_width: assert property (p_mask_width) else $error("bits above width pushed"); // [R7]

    c_word_done: cover property (startWord ##[1:20] wordDone_ff);
    c_fifo_full: cover property (enable_ff && fifoFull);
    c_irq: cover property ($rose(irq));
endmodule // programmable_crc_engine

/* shared/crc_params.svh */
// offsets, field positions and reset values of the crc engine
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CRC_ADDR_CTRL1 4'h0
`define CRC_ADDR_CTRL2 4'h1
`define CRC_ADDR_TERMS_LO 4'h2
`define CRC_ADDR_TERMS_HI 4'h3
`define CRC_ADDR_DATA_LO 4'h4
`define CRC_ADDR_DATA_HI 4'h5
`define CRC_ADDR_RESULT_LO 4'h6
`define CRC_ADDR_RESULT_HI 4'h7
`define CRC_ADDR_IRQ_STAT 4'h8
`define CRC_ADDR_IRQ_CLR 4'h9
`define CRC_ADDR_IRQ_EN 4'hA

// ****************************************************************
// field positions
// ****************************************************************
`define CRC_GO_BIT 4
`define CRC_EMPTY_BIT 6
`define CRC_FULL_BIT 7
`define CRC_COUNT_LSB 8
`define CRC_EN_BIT 15
`define CRC_POLY_LENGTH_FIELD_LSB 0
`define CRC_WIDTH_LSB 8

// ****************************************************************
// fifo depths by word width
// ****************************************************************
`define CRC_DEPTH_WIDE 5'h04
`define CRC_DEPTH_MID 5'h08
`define CRC_DEPTH_NARROW 5'h10
`define CRC_WIDTH_MID_MIN 5'h08
`define CRC_WIDTH_WIDE_MIN 5'h10

// ****************************************************************
// reset values
// ****************************************************************
`define CRC_RST_REG16 16'h0000
`define CRC_RST_REM 32'h00000000
`define CRC_RST_IRQ 3'h0

`endif

/* shared/crc_pkg.sv */
// types shared by the crc engine files
package crc_pkg;
    typedef enum logic {ST_IDLE, ST_SHIFT} eng_state_t;
    typedef logic [15:0] reg16_t;
    typedef logic [31:0] word32_t;
endpackage

/* verif/programmable_crc_engine_tb.sv */
// self-checking testbench for the programmable crc engine
`timescale 1ns/100ps
`include "crc_params.svh"
module programmable_crc_engine_tb
    import crc_pkg::*;
;
    // ************************************************************
    // clock, reset and bus signals
    // ************************************************************
    logic sys_clk;
    logic rst;
    logic [3:0] regAddr;
    reg16_t regWrData;
    logic regWrite;
    logic regRead;
    reg16_t regRdData;
    logic irq;
    int nErrors = 0;
    int samplesChecked = 0;
    int cycles = 0;
    localparam int LIMIT = 20000;
    logic [4:0] wfList [6] = '{5'h00, 5'h07, 5'h08, 5'h0F, 5'h10, 5'h1F};

    programmable_crc_engine dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdData(regRdData),
        .irq(irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // verdict, compare and bus tasks
    // ************************************************************
    task automatic end_sim();
        if (nErrors == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            nErrors++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input reg16_t d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rdVal(input logic [3:0] a, output reg16_t v);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        v = regRdData;
    endtask

    task automatic rdMask(input logic [3:0] a, input reg16_t m, input reg16_t e);
        reg16_t v;
        rdVal(a, v);
        chk({16'h0000, v & m}, {16'h0000, e});
    endtask

    // narrow words go in one write, wide words low half then high half
    task automatic pushWord(input logic [4:0] wf, input logic [31:0] w);
        wr(`CRC_ADDR_DATA_LO, w[15:0]);
        if (wf > 5'h0F)
            wr(`CRC_ADDR_DATA_HI, w[31:16]);
    endtask

    // ************************************************************
    // reference remainder
    // ************************************************************
    function automatic logic [31:0] maskOf(input logic [4:0] poly_length_field);
        maskOf = (poly_length_field == 5'h1F) ? 32'hFFFFFFFF : ((32'h00000001 << (poly_length_field + 1)) - 32'h00000001);
    endfunction

    function automatic logic [31:0] crcModel(input logic [31:0] rem, input logic [4:0] poly_length_field,
                                             input logic [31:0] terms, input logic [4:0] wf,
                                             input logic [31:0] d);
        logic [31:0] poly;
        logic fb;
        int i;
        poly = (terms | 32'h00000001) & maskOf(poly_length_field);
        for (i = int'(wf); i >= 0; i--) begin
            fb = rem[poly_length_field] ^ d[i];
            rem = (rem << 1) & maskOf(poly_length_field);
            if (fb)
                rem = rem ^ poly;
        end
        return rem;
    endfunction

    task automatic crcRun(input logic [4:0] poly_length_field, input logic [31:0] t, input logic [4:0] wf,
                          input int n, input logic [31:0] base, input logic [31:0] step);
        logic [31:0] exp;
        logic [31:0] w;
        reg16_t lo;
        reg16_t hi;
        int k;
        int c;
        exp = 32'h00000000;
        c = (int'(wf) + 2) / 2;
        wr(`CRC_ADDR_CTRL1, 16'h0000);
        wr(`CRC_ADDR_IRQ_CLR, 16'h0007);
        wr(`CRC_ADDR_IRQ_EN, 16'h0001);
        wr(`CRC_ADDR_CTRL2, {3'h0, wf, 3'h0, poly_length_field});
        wr(`CRC_ADDR_TERMS_LO, t[15:0]);
        wr(`CRC_ADDR_TERMS_HI, t[31:16]);
        wr(`CRC_ADDR_RESULT_LO, 16'h0000);
        wr(`CRC_ADDR_RESULT_HI, 16'h0000);
        wr(`CRC_ADDR_CTRL1, 16'h8000);
        for (k = 0; k < n; k++) begin
            w = base + step * k;
            pushWord(wf, w);
            exp = crcModel(exp, poly_length_field, t, wf, w);
        end
        @(posedge sys_clk);
        rdMask(`CRC_ADDR_CTRL1, 16'h1F00, 16'(n << 8));
        repeat (4) @(posedge sys_clk);
        rdMask(`CRC_ADDR_CTRL1, 16'h1F00, 16'(n << 8));
        chk({31'h0, irq}, 32'h00000000);
        wr(`CRC_ADDR_CTRL1, 16'h8010);
        if (wf == 5'h1F) begin
            repeat (3) @(posedge sys_clk);
            rdMask(`CRC_ADDR_CTRL1, 16'h1F00, 16'((n - 1) << 8));
            repeat (10) @(posedge sys_clk);
            #1;
            chk({31'h0, irq}, 32'h00000000);
            for (k = 0; k < 6 && irq !== 1'b1; k++) begin
                @(posedge sys_clk);
                #1;
            end
            chk({31'h0, irq}, 32'h00000001);
        end
        repeat (n * (c + 2) + 8) @(posedge sys_clk);
        rdVal(`CRC_ADDR_RESULT_LO, lo);
        rdVal(`CRC_ADDR_RESULT_HI, hi);
        chk({hi, lo} & maskOf(poly_length_field), exp);
        repeat (20) @(posedge sys_clk);
        rdVal(`CRC_ADDR_RESULT_LO, lo);
        rdVal(`CRC_ADDR_RESULT_HI, hi);
        chk({hi, lo} & maskOf(poly_length_field), exp);
        rdMask(`CRC_ADDR_CTRL1, 16'h1FC0, 16'h0040);
        rdMask(`CRC_ADDR_IRQ_STAT, 16'h0003, 16'h0003);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [4:0] d;
        int i;
        int j;
        rst = 1'b1;
        regAddr = 4'h0;
        regWrData = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rdMask(`CRC_ADDR_CTRL1, 16'h9F90, 16'h0000);
        wr(4'hB, 16'hFFFF);
        rdMask(4'hB, 16'hFFFF, 16'h0000);
        rdMask(4'hF, 16'hFFFF, 16'h0000);
        wr(`CRC_ADDR_IRQ_EN, 16'h0000);
        // fill to the width-dependent depth, one extra word refused
        for (i = 0; i < 6; i++) begin
            d = (wfList[i] > 5'h0F) ? 5'h04 : (wfList[i] > 5'h07) ? 5'h08 : 5'h10;
            wr(`CRC_ADDR_CTRL1, 16'h0000);
            wr(`CRC_ADDR_CTRL2, {3'h0, wfList[i], 8'h00});
            wr(`CRC_ADDR_CTRL1, 16'h8000);
            rdMask(`CRC_ADDR_CTRL1, 16'hFFFF, 16'h8040);
            for (j = 0; j <= int'(d); j++)
                pushWord(wfList[i], 32'(j));
            @(posedge sys_clk);
            rdMask(`CRC_ADDR_CTRL1, 16'hFFFF, 16'h8080 | {3'h0, d, 8'h00});
            rdMask(`CRC_ADDR_IRQ_STAT, 16'h0004, 16'h0004);
            chk({31'h0, irq}, 32'h00000000);
            wr(`CRC_ADDR_IRQ_EN, 16'h0004);
            #1;
            chk({31'h0, irq}, 32'h00000001);
            wr(`CRC_ADDR_IRQ_CLR, 16'h0004);
            #1;
            chk({31'h0, irq}, 32'h00000000);
            wr(`CRC_ADDR_IRQ_EN, 16'h0000);
            wr(`CRC_ADDR_CTRL1, 16'h0000);
            rdMask(`CRC_ADDR_CTRL1, 16'hFFFF, 16'h0040);
        end
        // wide word commits only with the half holding its top bit
        wr(`CRC_ADDR_CTRL2, 16'h1F1F);
        wr(`CRC_ADDR_CTRL1, 16'h8000);
        wr(`CRC_ADDR_DATA_LO, 16'h5A5A);
        @(posedge sys_clk);
        rdMask(`CRC_ADDR_CTRL1, 16'h1F00, 16'h0000);
        wr(`CRC_ADDR_DATA_HI, 16'hA5A5);
        @(posedge sys_clk);
        rdMask(`CRC_ADDR_CTRL1, 16'h1F00, 16'h0100);
        crcRun(5'h0F, 32'h00011020, 5'h07, 9, 32'h0000A531, 32'h00000001);
        crcRun(5'h1F, 32'h04C11DB7, 5'h1F, 2, 32'h12345678, 32'h9E3779B1);
        crcRun(5'h04, 32'h00000024, 5'h04, 6, 32'h0000FFE3, 32'h00000007);
        end_sim();
    end
endmodule // programmable_crc_engine_tb
